// >>> hw/spisb_port.sv
`timescale 1ns/1ns
`default_nettype none

// Notes on behaviour
// [RULE1] Loopback bit feeds the transmitter output straight into the receiver; resets clear.
// [RULE2] Framing error flags a bus conflict, only in four-wire master mode.
// [RULE3] Overrun sets when a new character lands before the previous was read.
// [RULE4] Reading the receive buffer clears overrun; software must not clear it. A status write can still clear it while soft reset hold is one.
// [RULE5] Busy reads one while a transfer is pending or running, else zero.
// [RULE6] Writable status bits change only while soft reset hold is one.
// [RULE7] Receive buffer low byte holds the last character; upper bits read zero.
// [RULE8] Reading the receive buffer clears receive error flags and receive flag.
// [RULE9] In seven-bit mode the received character is right aligned, bit 7 zero.
// [RULE10] Transmit buffer holds the next character; writing it clears the transmit flag.
// [RULE11] In seven-bit mode bit 7 of the transmit buffer is held zero.
// [RULE12] Interrupt enable: transmit at bit 1, receive at bit 0, reset disabled.
// [RULE13] Interrupt flags: transmit bit 1 resets one, receive bit 0 resets zero.
// [RULE14] Transmit flag sets when buffer empties; receive flag when a character arrives.
// [RULE15] Soft reset hold keeps the port logic in reset until cleared.
// [RULE16] Seven-bit select picks 8-bit characters at zero, 7-bit at one.
// [RULE17] Each interrupt request is high only while its flag and enable are one.
module spisb_port (
    input wire logic aclk, // Bus clock.
    input wire logic aresetn, // Synchronous reset, active low.
    input wire logic [spisb_pkg::SPISB_AW-1:0] awaddr, // Write address.
    input wire logic awvalid, // Write address valid.
    output logic awready, // Write address ready.
    input wire logic [spisb_pkg::SPISB_DW-1:0] wdata, // Write data.
    input wire logic [3:0] wstrb, // Write byte strobes.
    input wire logic wvalid, // Write data valid.
    output logic wready, // Write data ready.
    output logic [1:0] bresp, // Write response.
    output logic bvalid, // Write response valid.
    input wire logic bready, // Write response ready.
    input wire logic [spisb_pkg::SPISB_AW-1:0] araddr, // Read address.
    input wire logic arvalid, // Read address valid.
    output logic arready, // Read address ready.
    output logic [spisb_pkg::SPISB_DW-1:0] rdata, // Read data.
    output logic [1:0] rresp, // Read response.
    output logic rvalid, // Read data valid.
    input wire logic rready, // Read data ready.
    input wire logic bit_clk, // Bit clock source, link domain.
    output logic spi_sclk, // Serial clock out.
    output logic spi_mosi, // Serial data out.
    input wire logic spi_miso, // Serial data in.
    input wire logic spi_ste_n, // Other master's enable, low means conflict.
    output logic tx_irq, // Transmit interrupt request.
    output logic rx_irq // Receive interrupt request.
);
    import spisb_pkg::*;

    // ------------------------------------------------------------------
    // Bus-side state
    // ------------------------------------------------------------------
    logic [15:0] port_control;
    logic loopback_enable, framing_error_flag, overrun_error_flag;
    logic [7:0] rx_buffer, tx_buffer, tx_hold;
    logic tx_irq_enable, rx_irq_enable, tx_irq_flag, rx_irq_flag;
    logic rx_unread, tx_pending, tx_in_flight, tx_req_tog;
    logic aw_full, w_full;
    logic [7:0] wr_addr;
    logic [31:0] wr_data;
    logic [3:0] wr_strb;
    logic [3:0] from_link_s1, from_link_s2;
    logic [2:0] event_seen;

    // Link-side state
    logic [4:0] to_link_s1, to_link_s2;
    logic miso_s1, miso_s2, ste_s1, ste_s2, ste_prev;
    spisb_link_state_type link_state;
    logic [1:0] phase;
    logic [2:0] bit_cnt;
    logic [7:0] shreg, rx_hold;
    logic req_seen, ack_tog, rx_tog, fe_tog, link_busy;

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d,
                                            input logic [3:0] s);
        merge16 = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
    endfunction

    function automatic logic mapped(input logic [7:0] a);
        mapped = (a == SPISB_OFS_CTRL) || (a == SPISB_OFS_STAT) || (a == SPISB_OFS_RX) ||
                 (a == SPISB_OFS_TX) || (a == SPISB_OFS_IE) || (a == SPISB_OFS_IFG);
    endfunction

    // ------------------------------------------------------------------
    // Decoding
    // ------------------------------------------------------------------
    wire soft_reset_hold = port_control[SPISB_CTRL_SWRST];
    wire seven_bit_select = port_control[SPISB_CTRL_7BIT]; // RULE16
    wire four_wire = port_control[SPISB_CTRL_4WIRE];
    wire port_busy = tx_pending | tx_in_flight | from_link_s2[3]; // RULE5
    wire [2:0] link_events = (from_link_s2[2:0] ^ event_seen) & {3{~soft_reset_hold}};
    wire tx_ev = link_events[0];
    wire rx_ev = link_events[1];
    wire fe_ev = link_events[2];

    wire wr_exec = aw_full & w_full & ~bvalid;
    wire wr_ctrl = wr_exec & (wr_addr == SPISB_OFS_CTRL);
    wire wr_stat = wr_exec & (wr_addr == SPISB_OFS_STAT) & soft_reset_hold; // RULE6
    wire wr_tx = wr_exec & (wr_addr == SPISB_OFS_TX);
    wire wr_ie = wr_exec & (wr_addr == SPISB_OFS_IE);
    wire wr_ifg = wr_exec & (wr_addr == SPISB_OFS_IFG);
    wire rd_take = arvalid & arready;
    wire rd_rx = rd_take & (araddr == SPISB_OFS_RX);

    wire [15:0] status_word = {8'h00, loopback_enable, framing_error_flag, overrun_error_flag,
                               4'h0, port_busy};
    wire [15:0] ie_word = {14'h0000, tx_irq_enable, rx_irq_enable};
    wire [15:0] ifg_word = {14'h0000, tx_irq_flag, rx_irq_flag};
    wire [15:0] ctrl_new = merge16(port_control, wr_data, wr_strb);
    wire [15:0] stat_new = merge16(status_word, wr_data, wr_strb);
    wire [15:0] tx_new = merge16({8'h00, tx_buffer}, wr_data, wr_strb);
    wire [15:0] ie_new = merge16(ie_word, wr_data, wr_strb);
    wire [15:0] ifg_new = merge16(ifg_word, wr_data, wr_strb);
    wire [15:0] rd_word = (araddr == SPISB_OFS_CTRL) ? port_control :
                          (araddr == SPISB_OFS_STAT) ? status_word :
                          (araddr == SPISB_OFS_RX) ? {8'h00, rx_buffer} : // RULE7
                          (araddr == SPISB_OFS_TX) ? {8'h00, tx_buffer} :
                          (araddr == SPISB_OFS_IE) ? ie_word :
                          (araddr == SPISB_OFS_IFG) ? ifg_word : 16'h0000;

    // Control bits other than the hold bit are frozen while the port runs.
    wire [15:0] next_control = soft_reset_hold ? (ctrl_new & SPISB_CTRL_MASK) :
        ((port_control & ~16'h0001) | (ctrl_new & 16'h0001));
    // Hardware events win over a clear in the same cycle.
    wire next_rx_flag = rx_ev | (~rd_rx & (wr_ifg ? ifg_new[SPISB_IRQ_RX] : rx_irq_flag));
    wire next_tx_flag = tx_ev | (~wr_tx & (wr_ifg ? ifg_new[SPISB_IRQ_TX] : tx_irq_flag));
    wire next_oe = (rx_ev & rx_unread & ~rd_rx) |
                   (~rd_rx & (wr_stat ? stat_new[SPISB_STAT_OE] : overrun_error_flag));
    wire next_fe = fe_ev |
                   (~rd_rx & (wr_stat ? stat_new[SPISB_STAT_FE] : framing_error_flag));
    wire tx_launch = tx_pending & ~tx_in_flight & ~soft_reset_hold;
    wire [7:0] rx_in_char = seven_bit_select ? {1'b0, rx_hold[6:0]} : rx_hold;
    wire next_tx_en = wr_ie ? ie_new[SPISB_IRQ_TX] : tx_irq_enable;
    wire next_rx_en = wr_ie ? ie_new[SPISB_IRQ_RX] : rx_irq_enable;

    // ------------------------------------------------------------------
    // AXI4-Lite channels
    // ------------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awready <= 1'b1;
            wready <= 1'b1;
            aw_full <= 1'b0;
            w_full <= 1'b0;
            bvalid <= 1'b0;
            bresp <= SPISB_RESP_OKAY;
            wr_addr <= 8'h00;
            wr_data <= 32'h0000_0000;
            wr_strb <= 4'h0;
        end else begin
            if (awvalid && awready) begin
                awready <= 1'b0;
                aw_full <= 1'b1;
                wr_addr <= {awaddr[7:2], 2'b00};
            end
            if (wvalid && wready) begin
                wready <= 1'b0;
                w_full <= 1'b1;
                wr_data <= wdata;
                wr_strb <= wstrb;
            end
            if (wr_exec) begin
                aw_full <= 1'b0;
                w_full <= 1'b0;
                bvalid <= 1'b1;
                bresp <= mapped(wr_addr) ? SPISB_RESP_OKAY : SPISB_RESP_SLVERR;
            end
            if (bvalid && bready) begin
                bvalid <= 1'b0;
                awready <= 1'b1;
                wready <= 1'b1;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready <= 1'b1;
            rvalid <= 1'b0;
            rdata <= 32'h0000_0000;
            rresp <= SPISB_RESP_OKAY;
        end else if (rd_take) begin
            arready <= 1'b0;
            rvalid <= 1'b1;
            rdata <= {16'h0000, rd_word};
            rresp <= mapped(araddr) ? SPISB_RESP_OKAY : SPISB_RESP_SLVERR;
        end else if (rvalid && rready) begin
            rvalid <= 1'b0;
            arready <= 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // Registers and flags
    // ------------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            port_control <= SPISB_CTRL_RST;
            loopback_enable <= 1'b0;
            framing_error_flag <= 1'b0;
            overrun_error_flag <= 1'b0;
            tx_irq_enable <= SPISB_IE_RST[SPISB_IRQ_TX]; // RULE12
            rx_irq_enable <= SPISB_IE_RST[SPISB_IRQ_RX]; // RULE12
            tx_irq_flag <= SPISB_IFG_RST[SPISB_IRQ_TX]; // RULE13
            rx_irq_flag <= SPISB_IFG_RST[SPISB_IRQ_RX]; // RULE13
            rx_buffer <= SPISB_BUF_RST;
            tx_buffer <= SPISB_BUF_RST;
            rx_unread <= 1'b0;
        end else begin
            if (wr_ctrl) begin
                port_control <= next_control; // RULE6
            end
            if (wr_stat) begin
                loopback_enable <= stat_new[SPISB_STAT_LISTEN]; // RULE1
            end
            framing_error_flag <= next_fe; // RULE2
            overrun_error_flag <= next_oe; // RULE3 RULE4
            rx_irq_flag <= next_rx_flag; // RULE8 RULE14
            tx_irq_flag <= next_tx_flag; // RULE10 RULE14
            rx_unread <= rx_ev | (rx_unread & ~rd_rx);
            if (rx_ev) begin
                rx_buffer <= rx_in_char; // RULE9
            end
            if (wr_tx) begin
                tx_buffer <= {tx_new[7] & ~seven_bit_select, tx_new[6:0]}; // RULE11
            end
            if (wr_ie) begin
                tx_irq_enable <= ie_new[SPISB_IRQ_TX];
                rx_irq_enable <= ie_new[SPISB_IRQ_RX];
            end
        end
    end

    // Transmit hand-off: tx_hold stays still while a request is in flight.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            tx_pending <= 1'b0;
            tx_in_flight <= 1'b0;
            tx_req_tog <= 1'b0;
            tx_hold <= SPISB_BUF_RST;
            event_seen <= 3'h0;
            tx_irq <= 1'b0;
            rx_irq <= 1'b0;
        end else begin
            event_seen <= from_link_s2[2:0];
            tx_irq <= next_tx_flag & next_tx_en; // RULE17
            rx_irq <= next_rx_flag & next_rx_en; // RULE17
            if (soft_reset_hold) begin
                tx_pending <= 1'b0; // RULE15
                tx_in_flight <= 1'b0;
            end else begin
                tx_pending <= wr_tx | (tx_pending & ~tx_launch);
                tx_in_flight <= tx_launch | (tx_in_flight & ~tx_ev);
                if (tx_launch) begin
                    tx_req_tog <= ~tx_req_tog;
                    tx_hold <= tx_buffer;
                end
            end
        end
    end

    // Link to bus crossing: ack, received, conflict toggles and busy level.
    always_ff @(posedge aclk) begin
        from_link_s1 <= {link_busy, fe_tog, rx_tog, ack_tog};
        from_link_s2 <= from_link_s1;
    end

    // ------------------------------------------------------------------
    // Link domain
    // ------------------------------------------------------------------
    always_ff @(posedge bit_clk) begin
        to_link_s1 <= {soft_reset_hold, loopback_enable, seven_bit_select, four_wire,
                       tx_req_tog};
        to_link_s2 <= to_link_s1;
        miso_s1 <= spi_miso;
        miso_s2 <= miso_s1;
        ste_s1 <= spi_ste_n;
        ste_s2 <= ste_s1;
    end

    wire link_rst = to_link_s2[4];
    wire link_loop = to_link_s2[3];
    wire link_seven = to_link_s2[2];
    wire link_four = to_link_s2[1];
    wire link_req = to_link_s2[0];
    wire rx_in = link_loop ? spi_mosi : miso_s2; // RULE1
    wire [7:0] next_sh = {shreg[6:0], rx_in};
    wire last_bit = bit_cnt == (link_seven ? SPISB_LAST_BIT7 : SPISB_LAST_BIT8);

    always_ff @(posedge bit_clk) begin
        ste_prev <= ste_s2;
        if (link_rst) begin
            link_state <= SPISB_IDLE; // RULE15
            link_busy <= 1'b0;
            spi_sclk <= 1'b0;
            spi_mosi <= 1'b0;
            phase <= 2'h0;
            bit_cnt <= 3'h0;
            req_seen <= link_req;
            // Toggles restart at zero; the bus side masks the change under soft reset.
            ack_tog <= 1'b0;
            rx_tog <= 1'b0;
            fe_tog <= 1'b0;
        end else begin
            if (link_four && ste_prev && !ste_s2) begin
                fe_tog <= ~fe_tog; // RULE2
            end
            case (link_state)
                SPISB_IDLE: begin
                    if (link_req != req_seen) begin
                        req_seen <= link_req;
                        ack_tog <= ~ack_tog; // RULE14
                        shreg <= link_seven ? {tx_hold[6:0], 1'b0} : tx_hold;
                        link_state <= SPISB_SHIFT;
                        link_busy <= 1'b1; // RULE5
                        phase <= 2'h0;
                        bit_cnt <= 3'h0;
                    end
                end
                SPISB_SHIFT: begin
                    phase <= phase + 2'h1;
                    if (phase == 2'h0) begin
                        spi_mosi <= shreg[7];
                    end
                    if (phase == SPISB_PHASE_RISE) begin
                        spi_sclk <= 1'b1;
                    end
                    if (phase == SPISB_PHASE_LAST) begin
                        spi_sclk <= 1'b0;
                        shreg <= next_sh;
                        bit_cnt <= bit_cnt + 3'h1;
                        if (last_bit) begin
                            rx_hold <= next_sh;
                            rx_tog <= ~rx_tog;
                            link_state <= SPISB_IDLE;
                            link_busy <= 1'b0;
                        end
                    end
                end
                default: begin
                    link_state <= SPISB_IDLE;
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    sequence seq_rx_over;
        rx_ev && rx_unread && !rd_rx;
    endsequence

    sequence seq_tx_launch;
        tx_launch ##1 tx_in_flight;
    endsequence

    AST_LOOPBACK: assert property (@(posedge bit_clk) disable iff (link_rst) // RULE1
        (link_state == SPISB_SHIFT && link_loop && phase == SPISB_PHASE_LAST) |=>
        shreg[0] == $past(spi_mosi))
        else $error("loopback does not feed the receiver");
    AST_FE_MODE: assert property (@(posedge aclk) disable iff (!aresetn) // RULE2
        $rose(framing_error_flag) && !$past(wr_stat) |-> $past(four_wire))
        else $error("framing error outside four-wire mode");
    AST_OVERRUN: assert property (@(posedge aclk) disable iff (!aresetn) // RULE3
        seq_rx_over |=> overrun_error_flag)
        else $error("overrun not flagged");
    AST_OE_CLEAR: assert property (@(posedge aclk) disable iff (!aresetn) // RULE4
        rd_rx && !rx_ev && !fe_ev |=> rvalid && !overrun_error_flag && !framing_error_flag &&
        !rx_irq_flag)
        else $error("receive read left overrun or receive flag");
    AST_BUSY: assert property (@(posedge aclk) disable iff (!aresetn) // RULE5
        wr_tx && !soft_reset_hold |=> port_busy)
        else $error("busy low with a character pending");
    AST_LOCK: assert property (@(posedge aclk) disable iff (!aresetn) // RULE6
        $changed(loopback_enable) |-> $past(soft_reset_hold))
        else $error("status changed while port released");
    AST_RX_UPPER: assert property (@(posedge aclk) disable iff (!aresetn) // RULE7
        rd_rx |=> rdata == {24'h000000, $past(rx_buffer)})
        else $error("receive buffer read returned a wrong word");
    AST_RX_SEVEN: assert property (@(posedge aclk) disable iff (!aresetn) // RULE9
        rx_ev && seven_bit_select |=> rx_buffer[7] == 1'b0)
        else $error("seven-bit character has bit 7 set");
    AST_TX_WRITE: assert property (@(posedge aclk) disable iff (!aresetn) // RULE10
        wr_tx && !tx_ev |=> !tx_irq_flag)
        else $error("transmit write left transmit flag set");
    AST_TX_SEVEN: assert property (@(posedge aclk) disable iff (!aresetn) // RULE11
        wr_tx && seven_bit_select |=> tx_buffer[7] == 1'b0)
        else $error("seven-bit transmit byte has bit 7 set");
    AST_TX_EMPTY: assert property (@(posedge aclk) disable iff (!aresetn) // RULE14
        seq_tx_launch |-> ##[1:40] (!tx_in_flight))
        else $error("transmit hand-off never acknowledged");
    AST_SWRST: assert property (@(posedge aclk) disable iff (!aresetn) // RULE15
        soft_reset_hold |=> !tx_pending && !tx_in_flight)
        else $error("transfer pending under soft reset");
    AST_IRQ: assert property (@(posedge aclk) disable iff (!aresetn) // RULE17
        ##1 (tx_irq == (tx_irq_flag & tx_irq_enable)) && (rx_irq == (rx_irq_flag & rx_irq_enable)))
        else $error("interrupt request disagrees with flag and enable");

endmodule // spisb_port

`default_nettype wire

// >>> hw/spisb_pkg.sv
package spisb_pkg;

    // ------------------------------------------------------------------
    // Bus geometry and register map
    // ------------------------------------------------------------------
    localparam int SPISB_AW = 8;
    localparam int SPISB_DW = 32;
    localparam logic [7:0] SPISB_OFS_CTRL = 8'h00;
    localparam logic [7:0] SPISB_OFS_STAT = 8'h04;
    localparam logic [7:0] SPISB_OFS_RX = 8'h08;
    localparam logic [7:0] SPISB_OFS_TX = 8'h0c;
    localparam logic [7:0] SPISB_OFS_IE = 8'h10;
    localparam logic [7:0] SPISB_OFS_IFG = 8'h14;
    localparam logic [1:0] SPISB_RESP_OKAY = 2'h0;
    localparam logic [1:0] SPISB_RESP_SLVERR = 2'h2;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int SPISB_CTRL_SWRST = 0;
    localparam int SPISB_CTRL_4WIRE = 9;
    localparam int SPISB_CTRL_7BIT = 12;
    localparam int SPISB_STAT_LISTEN = 7;
    localparam int SPISB_STAT_FE = 6;
    localparam int SPISB_STAT_OE = 5;
    localparam int SPISB_STAT_BUSY = 0;
    localparam int SPISB_IRQ_TX = 1;
    localparam int SPISB_IRQ_RX = 0;

    // ------------------------------------------------------------------
    // Reset values and writable masks
    // ------------------------------------------------------------------
    localparam logic [15:0] SPISB_CTRL_RST = 16'h0001;
    localparam logic [15:0] SPISB_CTRL_MASK = 16'h1201;
    localparam logic [15:0] SPISB_IE_RST = 16'h0000;
    localparam logic [15:0] SPISB_IFG_RST = 16'h0002;
    localparam logic [7:0] SPISB_BUF_RST = 8'h00;

    // ------------------------------------------------------------------
    // Link timing: four bit clock cycles per bit, index of last bit
    // ------------------------------------------------------------------
    localparam logic [1:0] SPISB_PHASE_RISE = 2'h1;
    localparam logic [1:0] SPISB_PHASE_LAST = 2'h3;
    localparam logic [2:0] SPISB_LAST_BIT8 = 3'h7;
    localparam logic [2:0] SPISB_LAST_BIT7 = 3'h6;

    typedef enum logic {SPISB_IDLE, SPISB_SHIFT} spisb_link_state_type;

endpackage

// >>> verification/spisb_slave.sv
`timescale 1ns/1ns
`default_nettype none
module spisb_slave (
    input wire logic sclk, // Port clock.
    input wire logic mosi, // Port data out.
    input wire logic load, // Starts a frame.
    input wire logic [7:0] reply, // Answer character.
    output logic miso, // Data to the port.
    output logic [7:0] got // Bits received.
);
    int n;
    // Takes data on the rising clock and moves its own on the falling one.
    always @(posedge sclk) got <= {got[6:0], mosi};
    always @(negedge sclk or posedge load) begin
        n <= load ? 1 : n + 1;
        miso <= load ? reply[7] : (n < 8) ? reply[3'(7 - n)] : ~miso;
    end
endmodule // spisb_slave
`default_nettype wire

// >>> verification/testbench.sv
`timescale 1ns/1ns
`default_nettype none
module testbench;
    import spisb_pkg::*;
    localparam logic [7:0] c_st = SPISB_OFS_STAT, c_rx = SPISB_OFS_RX, c_tx = SPISB_OFS_TX;
    localparam logic [7:0] c_ie = SPISB_OFS_IE, c_fl = SPISB_OFS_IFG, c_ct = SPISB_OFS_CTRL;
    logic aclk = 1'h0, bit_clk = 1'h0, aresetn = 1'h0, spi_ste_n = 1'h1, load = 1'h0, cf = 1'h0;
    logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
    logic awready, wready, bvalid, arready, rvalid, spi_sclk, spi_mosi, spi_miso, tx_irq, rx_irq;
    logic [7:0] awaddr = 8'h0, araddr = 8'h0, reply = 8'h0, got, t, p;
    logic [31:0] wdata = 32'h0, rdata, q;
    logic [1:0] bresp, rresp, r;
    logic [7:0] ofs [5] = '{c_st, c_rx, c_tx, c_ie, c_fl};
    logic [31:0] rst [5] = '{32'h0, 32'h0, 32'h0, 32'h0, 32'h2};
    int error_cnt = 0, samples_checked = 0;
    initial forever #50 aclk = ~aclk;
    initial begin
        #7;
        forever #24 bit_clk = ~bit_clk;
    end
    spisb_port spisb_port_i (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb(4'hf),
        .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp,
        .rvalid, .rready, .bit_clk, .spi_sclk, .spi_mosi, .spi_miso, .spi_ste_n, .tx_irq, .rx_irq);
    spisb_slave spisb_slave_i (.sclk(spi_sclk), .mosi(spi_mosi), .load, .reply,
        .miso(spi_miso), .got);
    task automatic finish_test();
        $display("checks %0d mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        samples_checked++;
        if (g !== e) begin
            error_cnt++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        int i;
        @(posedge aclk);
        {awaddr, wdata, awvalid, wvalid, bready} <= {a, d, w, w, w};
        {araddr, arvalid, rready, load} <= {a, !w, !w, 1'h0};
        for (i = 0; i < 60; i++) begin
            @(posedge aclk);
            if (awready) awvalid <= 1'h0;
            if (wready) wvalid <= 1'h0;
            if (arready) arvalid <= 1'h0;
            if ((bvalid && bready) || (rvalid && rready)) break;
        end
        {q, r} = {rdata, w ? bresp : rresp};
        {bready, rready} <= 2'h0;
        if (i == 60) error_cnt++;
        if (i == 60) finish_test();
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] e);
        bus(1'h0, a, 32'h0);
        chk($sformatf("reg_%h", a), e, q);
    endtask
    // Sends one character while the slave answers, then waits until the port is idle.
    task automatic xfer(input logic [7:0] tc, input logic [7:0] pc);
        int i;
        {reply, load, spi_ste_n} <= {pc, 2'h3};
        bus(1'h1, c_tx, {24'h0, tc});
        bus(1'h0, c_st, 32'h0);
        chk("busy", 32'h1, 32'(q[0]));
        spi_ste_n <= !cf;
        for (i = 0; i < 40 && q[0] !== 1'h0; i++) bus(1'h0, c_st, 32'h0);
        if (i == 40) error_cnt++;
        if (i == 40) finish_test();
        repeat (4) @(posedge aclk);
    endtask
    initial begin
        void'($urandom(20512));
        repeat (20) @(posedge aclk);
        aresetn <= 1'h1;
        foreach (ofs[i]) rdc(ofs[i], rst[i]);
        rdc(c_ct, 32'h1);
        chk("irq", 32'h0, 32'({tx_irq, rx_irq}));
        bus(1'h0, 8'h18, 32'h0);
        chk("rresp", 32'(SPISB_RESP_SLVERR), 32'(r));
        bus(1'h1, c_st, 32'hffff);
        rdc(c_st, 32'he0);
        bus(1'h1, c_ie, 32'hffff);
        rdc(c_ie, 32'h3);
        bus(1'h1, c_fl, 32'h0);
        rdc(c_fl, 32'h0);
        bus(1'h1, c_fl, 32'h2);
        bus(1'h1, c_st, 32'h0);
        bus(1'h1, c_ct, 32'h0);
        bus(1'h1, c_st, 32'h80);
        rdc(c_st, 32'h0);
        bus(1'h1, c_ie, 32'h3);
        $display("test registers done");
        repeat (3) begin
            t = 8'($urandom);
            p = 8'($urandom);
            xfer(t, p);
            rdc(c_fl, 32'h3);
            chk("irq", 32'h3, 32'({tx_irq, rx_irq}));
            rdc(c_rx, {24'h0, p});
            chk("slave", {24'h0, t}, {24'h0, got});
            rdc(c_fl, 32'h2);
            chk("irq", 32'h2, 32'({tx_irq, rx_irq}));
        end
        $display("test transfers done");
        cf = 1'h1;
        xfer(t, 8'h5a);
        xfer(t, p);
        rdc(c_st, 32'h20);
        rdc(c_rx, {24'h0, p});
        rdc(c_st, 32'h0);
        $display("test overrun done");
        bus(1'h1, c_ct, 32'h1);
        bus(1'h1, c_st, 32'h80);
        bus(1'h1, c_ct, 32'h1000);
        xfer(t, ~t);
        rdc(c_rx, {25'h0, t[6:0]});
        rdc(c_tx, {25'h0, t[6:0]});
        bus(1'h1, c_ct, 32'h1);
        bus(1'h1, c_st, 32'h0);
        bus(1'h1, c_ct, 32'h200);
        xfer(t, p);
        rdc(c_st, 32'h40);
        rdc(c_rx, {24'h0, p});
        rdc(c_st, 32'h0);
        $display("test modes done");
        finish_test();
    end
endmodule // testbench
`default_nettype wire
